/* File: tws_status_flags.sv */
// status flags, interrupt enable/mask and pin-level start/stop watch of a two-wire controller
// assumes the serial engine runs on clk_in and sends one-cycle event pulses; bus pins are asynchronous
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "tws_defines.svh"

module tws_status_flags
   import tws_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   // register port
   input  wire logic [31:0]  reg_addr_in,
   input  wire logic [31:0]  reg_wdata_in,
   input  wire logic         reg_wr_in,
   input  wire logic         reg_rd_in,
   output logic      [31:0]  reg_rdata_out,
   // bus pins, asynchronous
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              scl_out,
   output logic              scl_oe_out,
   output logic              sda_out,
   output logic              sda_oe_out,
   // serial engine events, same clock
   input  wire logic         m_frame_start_in,
   input  wire logic         m_stop_sent_in,
   input  wire logic         tx_to_shifter_in,
   input  wire logic         rx_byte_load_in,
   input  wire logic [7:0]   rx_byte_in,
   input  wire logic         nack_in,
   input  wire logic         arb_lost_in,
   input  wire logic         s_addr_match_in,
   input  wire logic         s_dir_read_in,
   input  wire logic         s_addr_other_in,
   input  wire logic         s_general_call_in,
   input  wire logic         s_byte_acked_in,
   input  wire logic         s_ack_slot_in,
   input  wire logic         s_char_pending_in,
   // dma counter state, same clock
   input  wire logic         rx_cnt_zero_in,
   input  wire logic         rx_next_zero_in,
   input  wire logic         tx_cnt_zero_in,
   input  wire logic         tx_next_zero_in,
   input  wire logic         rx_cnt_wr_in,
   input  wire logic         tx_cnt_wr_in,
   // engine-side outputs
   output logic      [7:0]   tx_byte_out,
   output logic              tx_halt_out,
   output logic              master_enable_out,
   output logic              slave_enable_out,
   output logic      [6:0]   own_slave_address_out,
   output logic              irq_out
);

   // decode used by the register strobes and write processes; the read data process uses its own case
   function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
      hit = (a == off);
   endfunction : hit

   logic [15:0]  flags_r;
   logic [15:0]  irq_mask_r;
   logic [31:0]  rdata_r;
   logic [7:0]   rx_hold_r;
   logic [7:0]   tx_hold_r;
   logic         master_en_r;
   logic         sven_r;
   logic [6:0]   own_adr_r;
   logic         scl_s1_r;
   logic         scl_s2_r;
   logic         sda_s1_r;
   logic         sda_s2_r;
   logic         sda_d_r;
   logic         scl_oe_r;
   logic         sda_oe_r;
   logic         irq_r;
   logic         halt_r;

   tws_mode_type mode;
   logic         wr_ctrl;
   logic         wr_thr;
   logic         rd_sr;
   logic         rd_rhr;
   logic         pin_start;
   logic         pin_stop;
   logic         master_en_rise;
   logic         slave_access_drop;
   logic [15:0]  flags_nxt;

   assign mode      = master_en_r ? TWS_MODE_MASTER : TWS_MODE_SLAVE;
   assign wr_ctrl   = reg_wr_in & hit(reg_addr_in, `TWS_ADDR_CTRL);
   assign wr_thr    = reg_wr_in & hit(reg_addr_in, `TWS_ADDR_TX_HOLD);
   assign rd_sr     = reg_rd_in & hit(reg_addr_in, `TWS_ADDR_STATUS);
   assign rd_rhr    = reg_rd_in & hit(reg_addr_in, `TWS_ADDR_RX_HOLD);
   assign master_en_rise = wr_ctrl & reg_wdata_in[`TWS_CTRL_MASTER_EN] & ~master_en_r;

   // two-flop synchronisers on the pins; edges are found only on the second stage and beyond
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   // start and stop: data edge while clock is high
   assign pin_start = scl_s2_r & sda_d_r & ~sda_s2_r;
   assign pin_stop  = scl_s2_r & ~sda_d_r & sda_s2_r;

   // control and own address
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         master_en_r <= 1'b0;
         sven_r      <= 1'b0;
         own_adr_r   <= 7'h00;
      end else begin
         if (wr_ctrl) begin
            master_en_r <= reg_wdata_in[`TWS_CTRL_MASTER_EN];
            sven_r      <= reg_wdata_in[`TWS_CTRL_SVEN];
         end
         // address only takes effect while slave is disabled (sven_r low) or after a general call
         if (reg_wr_in && hit(reg_addr_in, `TWS_ADDR_SLAVE_ADR) && (!sven_r || flags_r[`TWS_B_GEN_CALL]))
            own_adr_r <= reg_wdata_in[`TWS_OWN_ADR_MSB:`TWS_OWN_ADR_LSB];
      end
   end

   // holding registers
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rx_hold_r <= 8'h00;
         tx_hold_r <= 8'h00;
      end else begin
         if (rx_byte_load_in)
            rx_hold_r <= rx_byte_in;
         if (wr_thr)
            tx_hold_r <= reg_wdata_in[7:0];
      end
   end

   // interrupt mask: set and clear ports, set wins if both hit one bit (they cannot, strobes are exclusive)
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_mask_r <= 16'h0000;
      end else if (reg_wr_in) begin
         if (hit(reg_addr_in, `TWS_ADDR_IRQ_SET))
            irq_mask_r <= irq_mask_r | (reg_wdata_in[15:0] & `TWS_IRQ_VALID);
         else if (hit(reg_addr_in, `TWS_ADDR_IRQ_CLR))
            irq_mask_r <= irq_mask_r & ~(reg_wdata_in[15:0] & `TWS_IRQ_VALID);
      end
   end

   assign slave_access_drop = flags_r[`TWS_B_SLV_ACCESS] & (pin_stop | nack_in) & ~s_addr_match_in;

   // next status; in every flag but the dma end flags a hardware set is applied after the clear so the set wins
   always_comb begin
      flags_nxt = flags_r;
      // transfer complete
      if (mode == TWS_MODE_MASTER) begin
         if (m_frame_start_in)
            flags_nxt[`TWS_B_XFER_DONE] = 1'b0;
         if (m_stop_sent_in || nack_in || arb_lost_in)
            flags_nxt[`TWS_B_XFER_DONE] = 1'b1;
      end else if (sven_r) begin
         if (pin_start)
            flags_nxt[`TWS_B_XFER_DONE] = 1'b0;
         if (pin_stop || s_addr_other_in)
            flags_nxt[`TWS_B_XFER_DONE] = 1'b1;
      end
      // receive ready
      if (rd_rhr)
         flags_nxt[`TWS_B_RX_READY] = 1'b0;
      if (rx_byte_load_in)
         flags_nxt[`TWS_B_RX_READY] = 1'b1;
      // transmit ready
      if (wr_thr)
         flags_nxt[`TWS_B_TX_READY] = 1'b0;
      if (mode == TWS_MODE_MASTER) begin
         if (tx_to_shifter_in || nack_in)
            flags_nxt[`TWS_B_TX_READY] = 1'b1;
      end else if (s_byte_acked_in) begin
         flags_nxt[`TWS_B_TX_READY] = 1'b1;
      end
      if (master_en_rise)
         flags_nxt[`TWS_B_TX_READY] = 1'b1;
      // slave access and direction
      if (mode == TWS_MODE_SLAVE && sven_r) begin
         if (slave_access_drop)
            flags_nxt[`TWS_B_SLV_ACCESS] = 1'b0;
         if (s_addr_match_in) begin
            flags_nxt[`TWS_B_SLV_ACCESS] = 1'b1;
            flags_nxt[`TWS_B_DIR_READ]   = s_dir_read_in;
         end
      end
      // clear-on-read flags
      if (rd_sr) begin
         flags_nxt[`TWS_B_GEN_CALL] = 1'b0;
         flags_nxt[`TWS_B_NACK]     = 1'b0;
         flags_nxt[`TWS_B_ARB_LOST] = 1'b0;
         flags_nxt[`TWS_B_SLV_END]  = 1'b0;
         if (flags_r[`TWS_B_XFER_DONE])
            flags_nxt[`TWS_B_OVERRUN] = 1'b0;
      end
      if (mode == TWS_MODE_SLAVE && s_general_call_in)
         flags_nxt[`TWS_B_GEN_CALL] = 1'b1;
      if (mode == TWS_MODE_MASTER && rx_byte_load_in && flags_r[`TWS_B_RX_READY])
         flags_nxt[`TWS_B_OVERRUN] = 1'b1;
      if (nack_in && (mode == TWS_MODE_MASTER || flags_r[`TWS_B_DIR_READ]))
         flags_nxt[`TWS_B_NACK] = 1'b1;
      if (mode == TWS_MODE_MASTER && arb_lost_in)
         flags_nxt[`TWS_B_ARB_LOST] = 1'b1;
      if (mode == TWS_MODE_SLAVE && slave_access_drop)
         flags_nxt[`TWS_B_SLV_END] = 1'b1;
      // clock stretch while the character boundary waits on software
      flags_nxt[`TWS_B_CLK_WAIT] = (mode == TWS_MODE_SLAVE) & flags_r[`TWS_B_SLV_ACCESS] & s_char_pending_in &
                                   (flags_r[`TWS_B_DIR_READ] ? flags_r[`TWS_B_TX_READY] & ~flags_r[`TWS_B_NACK]
                                                             : flags_r[`TWS_B_RX_READY]);
      // dma counters: a counter write restarts the watch, so here the write wins
      if (rx_cnt_wr_in)
         flags_nxt[`TWS_B_RX_END] = 1'b0;
      else if (rx_cnt_zero_in)
         flags_nxt[`TWS_B_RX_END] = 1'b1;
      if (tx_cnt_wr_in)
         flags_nxt[`TWS_B_TX_END] = 1'b0;
      else if (tx_cnt_zero_in)
         flags_nxt[`TWS_B_TX_END] = 1'b1;
      flags_nxt[`TWS_B_RX_FULL]  = rx_cnt_zero_in & rx_next_zero_in;
      flags_nxt[`TWS_B_TX_EMPTY] = tx_cnt_zero_in & tx_next_zero_in;
      flags_nxt[7] = 1'b0;
   end

   // status register
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         flags_r <= `TWS_FLAGS_RESET;
      else
         flags_r <= flags_nxt;
   end

   // read data stands the cycle after the strobe only
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_r <= `TWS_ZERO_WORD;
      end else if (!reg_rd_in) begin
         rdata_r <= `TWS_ZERO_WORD;
      end else begin
         unique case (reg_addr_in)
            `TWS_ADDR_CTRL:      rdata_r <= {30'h00000000, sven_r, master_en_r};
            `TWS_ADDR_SLAVE_ADR: rdata_r <= {9'h000, own_adr_r, 16'h0000};
            `TWS_ADDR_STATUS:    rdata_r <= {16'h0000, flags_r};
            `TWS_ADDR_IRQ_MASK:  rdata_r <= {16'h0000, irq_mask_r};
            `TWS_ADDR_RX_HOLD:   rdata_r <= {24'h000000, rx_hold_r};
            `TWS_ADDR_TX_HOLD:   rdata_r <= {24'h000000, tx_hold_r};
            default:             rdata_r <= `TWS_ZERO_WORD; // write-only and unmapped read zero
         endcase
      end
   end

   // pin drivers: stretch holds clock low, slave-write ack pulls data low
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else begin
         scl_oe_r <= flags_nxt[`TWS_B_CLK_WAIT];
         sda_oe_r <= (mode == TWS_MODE_SLAVE) & flags_r[`TWS_B_SLV_ACCESS] &
                     ~flags_r[`TWS_B_DIR_READ] & s_ack_slot_in;
      end
   end

   // halt and interrupt request
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         halt_r <= 1'b0;
         irq_r  <= 1'b0;
      end else begin
         halt_r <= flags_nxt[`TWS_B_TX_READY] & flags_nxt[`TWS_B_NACK];
         irq_r  <= |(flags_nxt & irq_mask_r & `TWS_IRQ_VALID);
      end
   end

   assign reg_rdata_out         = rdata_r;
   assign scl_out               = 1'b0;
   assign sda_out               = 1'b0;
   assign scl_oe_out            = scl_oe_r;
   assign sda_oe_out            = sda_oe_r;
   assign tx_byte_out           = tx_hold_r;
   assign tx_halt_out           = halt_r;
   assign master_enable_out     = master_en_r;
   assign slave_enable_out      = sven_r;
   assign own_slave_address_out = own_adr_r;
   assign irq_out               = irq_r;

endmodule : tws_status_flags

/* File: tws_defines.svh */
// register offsets, field positions, reset values and masks of the two-wire status block
// assumes byte addresses on a 32-bit word-aligned register port
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

`define TWS_ADDR_CTRL       32'h40018000
`define TWS_ADDR_SLAVE_ADR  32'h40018008
`define TWS_ADDR_STATUS     32'h40018020
`define TWS_ADDR_IRQ_SET    32'h40018024
`define TWS_ADDR_IRQ_CLR    32'h40018028
`define TWS_ADDR_IRQ_MASK   32'h4001802C
`define TWS_ADDR_RX_HOLD    32'h40018030
`define TWS_ADDR_TX_HOLD    32'h40018034

`define TWS_B_XFER_DONE     0
`define TWS_B_RX_READY      1
`define TWS_B_TX_READY      2
`define TWS_B_DIR_READ      3
`define TWS_B_SLV_ACCESS    4
`define TWS_B_GEN_CALL      5
`define TWS_B_OVERRUN       6
`define TWS_B_NACK          8
`define TWS_B_ARB_LOST      9
`define TWS_B_CLK_WAIT      10
`define TWS_B_SLV_END       11
`define TWS_B_RX_END        12
`define TWS_B_TX_END        13
`define TWS_B_RX_FULL       14
`define TWS_B_TX_EMPTY      15

`define TWS_CTRL_MASTER_EN  0
`define TWS_CTRL_SVEN       1
`define TWS_OWN_ADR_LSB     16
`define TWS_OWN_ADR_MSB     22

`define TWS_STATUS_RESET    32'h0000F009
`define TWS_FLAGS_RESET     16'hF009
`define TWS_IRQ_VALID       16'hFF77
`define TWS_ZERO_WORD       32'h00000000

`endif

/* File: tws_pkg.sv */
// types shared by the two-wire status block
// assumes nothing beyond a 32-bit register port
package tws_pkg;
   typedef logic [31:0] tws_word_type;
   typedef logic [15:0] tws_flags_type;
   typedef enum logic {TWS_MODE_SLAVE, TWS_MODE_MASTER} tws_mode_type;
endpackage : tws_pkg

/* File: tws_status_flags_monitor.sv */
// port-level checker for the two-wire status block
// assumes clk_in rising edge timing and an active-high asynchronous reset
`timescale 1ns/10ps
`include "tws_defines.svh"

module tws_status_flags_monitor
   import tws_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [31:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_rdata_out,
   input  wire logic        scl_oe_out,
   input  wire logic        sda_oe_out,
   input  wire logic        master_enable_out,
   input  wire logic        nack_in,
   input  wire logic        arb_lost_in,
   input  wire logic        s_ack_slot_in,
   input  wire logic        s_char_pending_in,
   input  wire logic        irq_out
);
   logic rd_st, armed_r, nk_r, ab_r;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   // a status read being taken this cycle
   assign rd_st = reg_rd_in && (reg_addr_in == `TWS_ADDR_STATUS);

   // sticky copies of master error events; a status read drops them, a new event wins
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nk_r <= 1'b0;
         ab_r <= 1'b0;
      end else begin
         nk_r <= (nack_in && master_enable_out) || (nk_r && !rd_st);
         ab_r <= (arb_lost_in && master_enable_out) || (ab_r && !rd_st);
      end
   end

   // no interrupt can be requested before any source was ever enabled
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) armed_r <= 1'b0;
      else if (reg_wr_in && reg_addr_in == `TWS_ADDR_IRQ_SET && reg_wdata_in[15:0] != 16'h0000) armed_r <= 1'b1;
   end

   chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == `TWS_ZERO_WORD)
      else $error("read data not zero outside a read answer");
   chk_status_resvd: assert property ($past(rd_st) |-> reg_rdata_out[31:16] == 16'h0000 && !reg_rdata_out[7])
      else $error("status reserved bits not zero");
   chk_mask_bits: assert property ($past(reg_rd_in && reg_addr_in == `TWS_ADDR_IRQ_MASK)
      |-> (reg_rdata_out & ~{16'h0000, `TWS_IRQ_VALID}) == `TWS_ZERO_WORD)
      else $error("mask shows a bit that has no source");
   chk_wo_read: assert property ($past(reg_rd_in && reg_addr_in == `TWS_ADDR_IRQ_SET)
      |-> reg_rdata_out == `TWS_ZERO_WORD)
      else $error("write-only enable port read back nonzero");
   chk_irq_unarmed: assert property (!armed_r |-> !irq_out)
      else $error("interrupt raised with no source enabled");
   chk_ack_slot: assert property ($rose(sda_oe_out) |-> $past(s_ack_slot_in))
      else $error("data line pulled outside an ack slot");
   chk_stretch_cause: assert property (scl_oe_out |-> $past(s_char_pending_in && !master_enable_out))
      else $error("clock stretched with no pending character");
   chk_nack_report: assert property ($past(rd_st && nk_r) |-> reg_rdata_out[`TWS_B_NACK])
      else $error("master not-acknowledge missing from status");
   chk_arb_report: assert property ($past(rd_st && ab_r) |-> reg_rdata_out[`TWS_B_ARB_LOST])
      else $error("arbitration loss missing from status");
endmodule : tws_status_flags_monitor

bind tws_status_flags tws_status_flags_monitor mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out),
   .master_enable_out(master_enable_out), .nack_in(nack_in), .arb_lost_in(arb_lost_in),
   .s_ack_slot_in(s_ack_slot_in), .s_char_pending_in(s_char_pending_in), .irq_out(irq_out));

/* File: tws_far_master.sv */
// far-end bus master: START, a run of clock pulses, then STOP
// assumes pull-ups on both lines and open-drain pull-down from the block
`timescale 1ns/10ps

module tws_far_master (
   input  wire logic frame_in,
   input  wire logic scl_oe_in,
   input  wire logic sda_oe_in,
   output logic      scl_out,
   output logic      sda_out
);
   logic scl_r, sda_r;

   // wired-and with pull-up, so a released line reads high
   assign scl_out = scl_r & ~scl_oe_in;
   assign sda_out = sda_r & ~sda_oe_in;

   // clock runs only inside a frame at 160 ns; it stands high between frames
   initial begin
      scl_r = 1'b1;
      sda_r = 1'b1;
      forever begin
         wait (frame_in);
         sda_r = 1'b0;
         while (frame_in) begin
            #80 scl_r = 1'b0;
            #80 scl_r = 1'b1;
         end
         #80 sda_r = 1'b1;
      end
   end
endmodule : tws_far_master

/* File: two_wire_status_irq_flags_bench.sv */
// self-checking bench for the two-wire status block with a far-end bus master
// assumes header, package, design, checker and far-end model are compiled first
`timescale 1ns/10ps
`include "tws_defines.svh"

module two_wire_status_irq_flags_bench
   import tws_pkg::*;
;
   localparam int E_FS = 0, E_SS = 1, E_SH = 2, E_RX = 3, E_NK = 4, E_AL = 5, E_AM = 6, E_GC = 7, E_AK = 8;
   localparam int E_RW = 9, E_TW = 10, E_AO = 11, E_BA = 12;
   logic         clk_in, sys_rst_in, reg_wr, reg_rd, frame, dir_rd, pend;
   logic         scl_w, sda_w, scl_oe, sda_oe, halt, irq, m_en;
   logic [12:0]  ev;
   logic [3:0]   zr;
   logic [7:0]   tx_byte;
   tws_word_type addr, wdata, rdata;
   int           err_total, samples_checked;

   tws_status_flags dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .scl_in(scl_w), .sda_in(sda_w),
      .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe), .m_frame_start_in(ev[E_FS]),
      .m_stop_sent_in(ev[E_SS]), .tx_to_shifter_in(ev[E_SH]), .rx_byte_load_in(ev[E_RX]), .rx_byte_in(8'h5A),
      .nack_in(ev[E_NK]), .arb_lost_in(ev[E_AL]), .s_addr_match_in(ev[E_AM]), .s_dir_read_in(dir_rd),
      .s_addr_other_in(ev[E_AO]), .s_general_call_in(ev[E_GC]), .s_byte_acked_in(ev[E_BA]),
      .s_ack_slot_in(ev[E_AK]), .s_char_pending_in(pend), .rx_cnt_zero_in(zr[0]), .rx_next_zero_in(zr[1]),
      .tx_cnt_zero_in(zr[2]), .tx_next_zero_in(zr[3]), .rx_cnt_wr_in(ev[E_RW]), .tx_cnt_wr_in(ev[E_TW]),
      .tx_byte_out(tx_byte), .tx_halt_out(halt), .master_enable_out(m_en), .slave_enable_out(),
      .own_slave_address_out(), .irq_out(irq));
   tws_far_master far (.frame_in(frame), .scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_out(scl_w), .sda_out(sda_w));

   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task chk(input tws_word_type seen, input tws_word_type exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   // trailing edge keeps a second write from re-raising the strobe in the same step
   task wr(input tws_word_type a, input tws_word_type d);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      @(posedge clk_in);
   endtask : wr

   // read data stand only in the cycle after the strobe
   task rc(input tws_word_type a, input tws_word_type exp);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge clk_in);
   endtask : rc

   task pulse(input int a, input int b);
      ev <= (13'h0001 << a) | (13'h0001 << b);
      @(posedge clk_in);
      ev <= '0;
      @(posedge clk_in);
   endtask : pulse

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      stop_test();
   end

   initial begin
      sys_rst_in = 1'b1;
      {reg_wr, reg_rd, frame, dir_rd, pend} = 5'h00;
      addr = 32'h00000000;
      wdata = 32'h00000000;
      ev = '0;
      zr = 4'hF;
      err_total = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rc(`TWS_ADDR_STATUS, 32'h0000F009);
      rc(`TWS_ADDR_IRQ_MASK, 32'h00000000);
      rc(`TWS_ADDR_IRQ_SET, 32'h00000000);
      rc(32'h40018040, 32'h00000000);
      wr(`TWS_ADDR_IRQ_SET, 32'h0000FFFF);
      rc(`TWS_ADDR_IRQ_MASK, 32'h0000FF77);
      chk(32'(irq), 32'h00000001);
      wr(`TWS_ADDR_IRQ_CLR, 32'h0000F001);
      rc(`TWS_ADDR_IRQ_MASK, 32'h00000F76);
      chk(32'(irq), 32'h00000000);
      // master: enable, double load overruns, holding write, shifter load, stop
      wr(`TWS_ADDR_CTRL, 32'h00000001);
      pulse(E_RX, E_RX);
      pulse(E_RX, E_RX);
      rc(`TWS_ADDR_STATUS, 32'h0000F04F);
      rc(`TWS_ADDR_RX_HOLD, 32'h0000005A);
      rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      wr(`TWS_ADDR_TX_HOLD, 32'h000000A5);
      pulse(E_FS, E_FS);
      rc(`TWS_ADDR_STATUS, 32'h0000F008);
      chk(32'(tx_byte), 32'h000000A5);
      pulse(E_SH, E_SH);
      rc(`TWS_ADDR_STATUS, 32'h0000F00C);
      pulse(E_SS, E_SS);
      rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      // not-acknowledge then arbitration loss; holding stays unwritten while halted
      for (int k = 0; k < 2; k++) begin
         pulse(E_FS, E_FS);
         pulse(E_NK + k, E_NK + k);
         chk(32'(halt), 32'(k == 0));
         rc(`TWS_ADDR_STATUS, 32'h0000F00D | (32'h00000100 << k));
         rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      end
      // counter writes restart the end watch, zero counters set the flags
      zr <= 4'h0;
      pulse(E_RW, E_TW);
      rc(`TWS_ADDR_STATUS, 32'h0000000D);
      zr <= 4'h5;
      @(posedge clk_in);
      rc(`TWS_ADDR_STATUS, 32'h0000300D);
      zr <= 4'hF;
      @(posedge clk_in);
      rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      // slave write access: start, match, ack, stretch, stop
      wr(`TWS_ADDR_CTRL, 32'h00000002);
      frame <= 1'b1;
      repeat (6) @(posedge clk_in);
      rc(`TWS_ADDR_STATUS, 32'h0000F00C);
      pulse(E_AM, E_AM);
      rc(`TWS_ADDR_STATUS, 32'h0000F014);
      ev[E_AK] <= 1'b1;
      @(posedge clk_in);
      ev <= '0;
      #1 chk(32'(sda_oe), 32'h00000001);
      @(posedge clk_in);
      pulse(E_RX, E_RX);
      pend <= 1'b1;
      @(posedge clk_in);
      #1 chk(32'(scl_oe), 32'h00000001);
      rc(`TWS_ADDR_STATUS, 32'h0000F416);
      rc(`TWS_ADDR_RX_HOLD, 32'h0000005A);
      #1 chk(32'(scl_oe), 32'h00000000);
      pend <= 1'b0;
      frame <= 1'b0;
      repeat (20) @(posedge clk_in);
      rc(`TWS_ADDR_STATUS, 32'h0000F805);
      rc(`TWS_ADDR_STATUS, 32'h0000F005);
      pulse(E_GC, E_GC);
      rc(`TWS_ADDR_STATUS, 32'h0000F025);
      rc(`TWS_ADDR_STATUS, 32'h0000F005);
      // slave read access ended by the master's not-acknowledge
      dir_rd <= 1'b1;
      pulse(E_AM, E_AM);
      pulse(E_NK, E_NK);
      rc(`TWS_ADDR_STATUS, 32'h0000F90D);
      rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      // slave holding write and ack, then a foreign address after a start
      wr(`TWS_ADDR_TX_HOLD, 32'h0000003C);
      rc(`TWS_ADDR_STATUS, 32'h0000F009);
      pulse(E_BA, E_BA);
      rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      frame <= 1'b1;
      repeat (6) @(posedge clk_in);
      rc(`TWS_ADDR_STATUS, 32'h0000F00C);
      pulse(E_AO, E_AO);
      rc(`TWS_ADDR_STATUS, 32'h0000F00D);
      frame <= 1'b0;
      stop_test();
   end
endmodule : two_wire_status_irq_flags_bench
